/* shared/mlrc_pkg.sv */
// Constants and types shared by the low-power rate configuration block
package mlrc_pkg;
  // Register addresses on the register port
  localparam logic [7:0] MLRC_ADDR_LPC    = 8'h1e;
  localparam logic [7:0] MLRC_ADDR_WAKE_X = 8'h20;
  localparam logic [7:0] MLRC_ADDR_WAKE_Y = 8'h21;
  localparam logic [7:0] MLRC_ADDR_WAKE_Z = 8'h22;
  localparam logic [7:0] MLRC_ADDR_FIFO   = 8'h23;
  // Field positions of the low-power control register
  localparam int MLRC_LPC_CYCLE_BIT = 7;
  localparam int MLRC_LPC_AVG_MSB   = 6;
  localparam int MLRC_LPC_AVG_LSB   = 4;
  // Writable bits; reserved bits read as zero
  localparam logic [7:0] MLRC_LPC_WMASK  = 8'hf0;
  localparam logic [7:0] MLRC_FIFO_WMASK = 8'hf8;
  // Reset values
  localparam logic [7:0] MLRC_RST_REG = 8'h00;
  localparam logic [7:0] MLRC_RST_DIV = 8'h00;
  // Sample counts at code zero: gyro averaging and accel decimator
  localparam logic [7:0] MLRC_GYRO_AVG_BASE = 8'h01;
  localparam logic [7:0] MLRC_ACC_AVG_BASE  = 8'h04;
  // Source of the output rate
  typedef enum logic [1:0] {
    MLRC_SRC_GYRO,
    MLRC_SRC_ACC,
    MLRC_SRC_ACC_LP
  } mlrc_src_t;
endpackage

/* shared/mlrc_div_if.sv */
// Carrier between the configuration top and its rate divider
`timescale 1ns/10ps
`default_nettype none
interface mlrc_div_if;
  logic       tick_in;
  logic       div_en;
  logic [7:0] div_val;
  logic       tick_out;
  modport cfg (output tick_in, output div_en, output div_val, input tick_out);
  modport div (input tick_in, input div_en, input div_val, output tick_out);
endinterface
`default_nettype wire

/* rtl/mlrc_rate_div.sv */
// Output rate divider: passes one sample tick out of every div_val plus one
`timescale 1ns/10ps
`default_nettype none
module mlrc_rate_div
  import mlrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  mlrc_div_if.div   bus
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } mlrc_div_state_t;

  mlrc_div_state_t s_r;
  mlrc_div_state_t s_nxt;

  // Count input ticks; bypass the count when division is off
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (bus.tick_in) begin
      if (!bus.div_en || s_r.cnt >= bus.div_val) begin
        s_nxt.cnt  = MLRC_RST_DIV;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.tick_out = s_r.tick;
endmodule
`default_nettype wire

/* rtl/mlrc_top.sv */
// Low-power rate configuration, wake thresholds and deferred FIFO enables
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - With any gyro axis powered, the rate comes from the gyro bypass choice and the low-pass setting, or the averaging while duty cycling.
// - With all gyro axes off and accel normal, the rate comes from accel bypass and low-pass setting.
// - With all gyro axes off and accel low-power, the rate comes from accel bypass and the decimator averaging.
// - Bit 7 of the low-power control register enables gyro duty cycling, set by the host for it.
// - Bits 6 to 4 choose gyro duty-cycle averaging of 1 to 128 samples, doubling per code.
// - While gyro duty cycling runs, gyro filtering follows averaging and ignores the low-pass setting.
// - Three independent 8-bit wake-on-motion thresholds exist for accel X, Y and Z.
// - Written FIFO enables take effect only when the sequence controller is idle.
// - The filtered rate is divided by one plus the 8-bit divider, only at 1 kHz sampling.
// - Decimator averaging codes 0 to 3 average 4, 8, 16 or 32 samples.
module mlrc_top
  import mlrc_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,

  // Register port
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output var  logic [7:0] REG_RDATA,
  output var  logic       REG_RVALID,

  // Sensor power state and filter choices
  input  wire logic [2:0] GYRO_AXIS_ON,
  input  wire logic       ACCEL_LP_MODE,
  input  wire logic       GYRO_BYPASS,
  input  wire logic       ACCEL_BYPASS,
  input  wire logic [2:0] LPF_CFG,
  input  wire logic [1:0] ACCEL_DEC_AVG,

  // Sample timing and sequencer state
  input  wire logic [7:0] RATE_DIV,
  input  wire logic       SAMPLE_1KHZ,
  input  wire logic       SAMPLE_TICK,
  input  wire logic       SEQ_IDLE,

  // Selected rate source and filter settings
  output var  logic [1:0] RATE_SRC,
  output var  logic       FILT_BYPASS,
  output var  logic       FILT_USE_LPF,
  output var  logic [2:0] FILT_LPF_CFG,
  output var  logic [7:0] AVG_SAMPLES,
  output var  logic       GYRO_CYCLE_EN,

  // Thresholds, applied FIFO enables and divided tick
  output var  logic [7:0] WAKE_X_LEVEL,
  output var  logic [7:0] WAKE_Y_LEVEL,
  output var  logic [7:0] WAKE_Z_LEVEL,
  output var  logic [7:0] FIFO_EN_ACTIVE,
  output var  logic       OUT_TICK
);
  // Whole state of the block in one record
  typedef struct packed {
    // Host registers
    logic [7:0] lpc;
    logic [7:0] wake_x;
    logic [7:0] wake_y;
    logic [7:0] wake_z;

    // FIFO enables: written, applied, change pending
    logic [7:0] fifo_pend;
    logic [7:0] fifo_act;
    logic       fifo_chg;

    // Read answer
    logic [7:0] rdata;
    logic       rvalid;

    // Rate selection results
    mlrc_src_t  src;
    logic       bypass;
    logic       use_lpf;
    logic [2:0] lpf;
    logic [7:0] avg;
  } mlrc_top_state_t;

  // Registered state and its next value
  mlrc_top_state_t s_r;
  mlrc_top_state_t s_nxt;

  // Carrier to the rate divider
  mlrc_div_if      div_bus ();

  // Gyro power and duty-cycle controls
  logic       gyro_on;
  logic       gyro_cycle;
  logic [2:0] gyro_avg_sel;

  // Any powered gyro axis makes the gyro the rate source
  assign gyro_on      = |GYRO_AXIS_ON;
  // Duty-cycle enable and averaging code from the low-power control register
  assign gyro_cycle   = s_r.lpc[MLRC_LPC_CYCLE_BIT];
  assign gyro_avg_sel = s_r.lpc[MLRC_LPC_AVG_MSB:MLRC_LPC_AVG_LSB];

  // Register port, deferred FIFO enables and rate source selection
  always_comb begin
    // Hold every register; the read answer lasts one cycle
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;

    // FIFO enables move to the active set only at sequencer idle
    // Holding a pending copy keeps a running sequence from seeing a change
    if (SEQ_IDLE && s_r.fifo_chg) begin
      s_nxt.fifo_act = s_r.fifo_pend;
      s_nxt.fifo_chg = 1'b0;
    end

    // Register writes; a write beside an apply re-arms the pending flag
    if (REG_WR) begin
      case (REG_ADDR)
        MLRC_ADDR_LPC:    s_nxt.lpc    = REG_WDATA & MLRC_LPC_WMASK;
        MLRC_ADDR_WAKE_X: s_nxt.wake_x = REG_WDATA;
        MLRC_ADDR_WAKE_Y: s_nxt.wake_y = REG_WDATA;
        MLRC_ADDR_WAKE_Z: s_nxt.wake_z = REG_WDATA;
        MLRC_ADDR_FIFO: begin
          // Reserved low bits are dropped here, so they read as zero
          s_nxt.fifo_pend = REG_WDATA & MLRC_FIFO_WMASK;
          s_nxt.fifo_chg  = 1'b1;
        end
        default: ;
      endcase
    end

    // Register reads answer one cycle later; unmapped reads return zero
    // A read beside a write to the same register returns the old value
    if (REG_RD) begin
      s_nxt.rvalid = 1'b1;
      case (REG_ADDR)
        MLRC_ADDR_LPC:    s_nxt.rdata = s_r.lpc;
        MLRC_ADDR_WAKE_X: s_nxt.rdata = s_r.wake_x;
        MLRC_ADDR_WAKE_Y: s_nxt.rdata = s_r.wake_y;
        MLRC_ADDR_WAKE_Z: s_nxt.rdata = s_r.wake_z;
        MLRC_ADDR_FIFO:   s_nxt.rdata = s_r.fifo_pend;
        default:          s_nxt.rdata = MLRC_RST_REG;
      endcase
    end

    // Rate source: gyro first, then accel low-power, then accel normal
    if (gyro_on) begin
      s_nxt.src    = MLRC_SRC_GYRO;
      s_nxt.bypass = GYRO_BYPASS;
      if (gyro_cycle) begin
        // Duty cycling: averaging depth stands in for the low-pass setting
        s_nxt.use_lpf = 1'b0;
        s_nxt.lpf     = 3'h0;
        s_nxt.avg     = MLRC_GYRO_AVG_BASE << gyro_avg_sel;
      end else begin
        // Continuous gyro: low-pass setting governs, no averaging
        s_nxt.use_lpf = 1'b1;
        s_nxt.lpf     = LPF_CFG;
        s_nxt.avg     = MLRC_GYRO_AVG_BASE;
      end
    end else if (ACCEL_LP_MODE) begin
      // Accel low-power: decimator averaging sets the rate
      s_nxt.src     = MLRC_SRC_ACC_LP;
      s_nxt.bypass  = ACCEL_BYPASS;
      s_nxt.use_lpf = 1'b0;
      s_nxt.lpf     = 3'h0;
      s_nxt.avg     = MLRC_ACC_AVG_BASE << ACCEL_DEC_AVG;
    end else begin
      // Accel normal: low-pass setting governs, no averaging
      s_nxt.src     = MLRC_SRC_ACC;
      s_nxt.bypass  = ACCEL_BYPASS;
      s_nxt.use_lpf = 1'b1;
      s_nxt.lpf     = LPF_CFG;
      s_nxt.avg     = MLRC_GYRO_AVG_BASE;
    end
  end

  // State register
  // Synchronous reset clears every field to zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Divider sees the internal sample tick; division only at 1 kHz sampling
  assign div_bus.tick_in = SAMPLE_TICK;
  // Outside 1 kHz sampling every tick passes
  assign div_bus.div_en  = SAMPLE_1KHZ;
  assign div_bus.div_val = RATE_DIV;

  // Rate divider; its count is kept when the divider value or mode changes
  mlrc_rate_div u_div (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .bus (div_bus.div)
  );

  // Outputs straight from state flip-flops
  assign REG_RDATA      = s_r.rdata;
  assign REG_RVALID     = s_r.rvalid;

  // Rate source and filter settings
  assign RATE_SRC       = s_r.src;
  assign FILT_BYPASS    = s_r.bypass;
  assign FILT_USE_LPF   = s_r.use_lpf;
  assign FILT_LPF_CFG   = s_r.lpf;
  assign AVG_SAMPLES    = s_r.avg;

  // Duty-cycle enable, thresholds and applied FIFO enables
  assign GYRO_CYCLE_EN  = s_r.lpc[MLRC_LPC_CYCLE_BIT];
  assign WAKE_X_LEVEL   = s_r.wake_x;
  assign WAKE_Y_LEVEL   = s_r.wake_y;
  assign WAKE_Z_LEVEL   = s_r.wake_z;
  assign FIFO_EN_ACTIVE = s_r.fifo_act;

  // Divided sample tick, registered inside the divider
  assign OUT_TICK       = div_bus.tick_out;
endmodule
`default_nettype wire

/* test/mlrc_top_properties.sv */
// Port-level checks of the rate configuration top
`timescale 1ns/10ps
`default_nettype none
module mlrc_props
  import mlrc_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       SYS_RST,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  input wire logic [2:0] GYRO_AXIS_ON,
  input wire logic       ACCEL_LP_MODE,
  input wire logic [1:0] ACCEL_DEC_AVG,
  input wire logic       SEQ_IDLE,
  input wire logic [1:0] RATE_SRC,
  input wire logic       FILT_USE_LPF,
  input wire logic [7:0] AVG_SAMPLES,
  input wire logic       GYRO_CYCLE_EN,
  input wire logic [7:0] FIFO_EN_ACTIVE
);
  logic live_r;
  // High once the previous edge was out of reset
  always_ff @(posedge CLK_SYS) live_r <= !SYS_RST;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  src_gyro_a: assert property (live_r && |GYRO_AXIS_ON |=> RATE_SRC == 2'h0)
    else $error("gyro source lost");
  src_acc_a: assert property (live_r && GYRO_AXIS_ON == 3'h0 && !ACCEL_LP_MODE
    |=> RATE_SRC == 2'h1 && FILT_USE_LPF) else $error("accel source wrong");
  src_lowpow_a: assert property (live_r && GYRO_AXIS_ON == 3'h0 && ACCEL_LP_MODE
    |=> RATE_SRC == 2'h2 && AVG_SAMPLES == 8'h04 << $past(ACCEL_DEC_AVG)) else $error("lp avg");
  cycle_nolpf_a: assert property (live_r && |GYRO_AXIS_ON && GYRO_CYCLE_EN |=> !FILT_USE_LPF)
    else $error("lpf used while cycling");
  cycle_bit_a: assert property (REG_WR && REG_ADDR == MLRC_ADDR_LPC
    |=> GYRO_CYCLE_EN == $past(REG_WDATA[7])) else $error("cycle bit");
  read_valid_a: assert property (live_r |-> REG_RVALID == $past(REG_RD))
    else $error("read answer timing");
  lpc_low_a: assert property (REG_RD && REG_ADDR == MLRC_ADDR_LPC |=> REG_RDATA[3:0] == 4'h0)
    else $error("reserved bits set");
  fifo_hold_a: assert property (live_r && !SEQ_IDLE |=> $stable(FIFO_EN_ACTIVE))
    else $error("fifo enable moved");
endmodule
bind mlrc_top mlrc_props u_props (.*);
`default_nettype wire

/* test/mlrc_host.sv */
// Host model: single-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module mlrc_host (
  input  wire logic       CLK_SYS,
  output var  logic       REG_WR,
  output var  logic       REG_RD,
  output var  logic [7:0] REG_ADDR,
  output var  logic [7:0] REG_WDATA
);
  initial {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = 18'h0;
  // Strobe for one edge, then scramble the released lines
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
    @(negedge CLK_SYS);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* test/mlrc_top_tb.sv */
// Self-checking bench of the rate configuration top
`timescale 1ns/10ps
`default_nettype none
module mlrc_top_tb;
  import mlrc_pkg::*;
  logic       clk, rst, wen, ren, rv, lp, gby, aby, k1, tk, idle, fby, ulpf, cyc, ot;
  logic [2:0] gon, lpf, flpf;
  logic [1:0] dec, src;
  logic [7:0] adr, wd, rdt, div, avg, wx, wy, wz, fifo;
  logic [7:0] w[4];
  logic [7:0] regs[4] = '{MLRC_ADDR_LPC, MLRC_ADDR_WAKE_X, MLRC_ADDR_WAKE_Y, MLRC_ADDR_WAKE_Z};
  logic [7:0] q[$];
  int         miscompares = 0, comparisons = 0, nt = 0, seed = 83541;
  mlrc_host host (.CLK_SYS(clk), .REG_WR(wen), .REG_RD(ren), .REG_ADDR(adr), .REG_WDATA(wd));
  mlrc_top uut (.CLK_SYS(clk), .SYS_RST(rst), .REG_WR(wen), .REG_RD(ren), .REG_ADDR(adr),
    .REG_WDATA(wd), .REG_RDATA(rdt), .REG_RVALID(rv), .GYRO_AXIS_ON(gon), .ACCEL_LP_MODE(lp),
    .GYRO_BYPASS(gby), .ACCEL_BYPASS(aby), .LPF_CFG(lpf), .ACCEL_DEC_AVG(dec), .RATE_DIV(div),
    .SAMPLE_1KHZ(k1), .SAMPLE_TICK(tk), .SEQ_IDLE(idle), .RATE_SRC(src), .FILT_BYPASS(fby),
    .FILT_USE_LPF(ulpf), .FILT_LPF_CFG(flpf), .AVG_SAMPLES(avg), .GYRO_CYCLE_EN(cyc),
    .WAKE_X_LEVEL(wx), .WAKE_Y_LEVEL(wy), .WAKE_Z_LEVEL(wz), .FIFO_EN_ACTIVE(fifo), .OUT_TICK(ot));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Note the expected answer, then issue the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  task automatic pulse;
    @(negedge clk) tk = 1'b1;
    @(negedge clk) tk = 1'b0;
  endtask
  task automatic end_sim;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Pairs each read answer with the oldest note; counts passed ticks
  always @(posedge clk) begin
    #1;
    if (rv === 1'b1) chk(rdt, q.pop_front());
    if (ot === 1'b1) nt++;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_sim;
  end
  initial begin
    {rst, gon, lp, gby, aby, lpf, dec, div, k1, tk, idle} = {1'b1, 22'h0};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    foreach (regs[i]) begin
      w[i] = 8'($random(seed));
      host.acc(1'b1, regs[i], w[i]);
    end
    foreach (regs[i]) rd(regs[i], i == 0 ? w[i] & MLRC_LPC_WMASK : w[i]);
    rd(8'h1f, 8'h00);
    chk(wx, w[1]);
    chk(wy, w[2]);
    chk(wz, w[3]);
    // Non-zero random low-pass setting that duty cycling must hide
    lpf = 3'($random(seed)) | 3'h1;
    gon = 3'h4;
    for (int c = 0; c < 8; c++) begin
      host.acc(1'b1, MLRC_ADDR_LPC, {1'b1, 3'(c), 4'hf});
      @(negedge clk);
      chk(avg, 8'h01 << c);
      chk({cyc, 3'h0, flpf, ulpf}, 8'h80);
    end
    gby = 1'b1;
    host.acc(1'b1, MLRC_ADDR_LPC, 8'h00);
    @(negedge clk);
    chk({src, ulpf, fby, 1'b0, flpf}, {4'h3, 1'b0, lpf});
    {gon, lp, aby} = 5'h03;
    for (int k = 0; k < 4; k++) begin
      dec = 2'(k);
      @(negedge clk);
      chk(avg, 8'h04 << k);
      chk({src, ulpf, fby, 1'b0, flpf}, 8'h90);
    end
    {lp, aby} = 2'b00;
    @(negedge clk);
    chk({src, ulpf, fby, 1'b0, flpf}, {4'h6, 1'b0, lpf});
    host.acc(1'b1, MLRC_ADDR_FIFO, 8'hff);
    repeat (3) @(negedge clk);
    chk(fifo, 8'h00);
    rd(MLRC_ADDR_FIFO, MLRC_FIFO_WMASK);
    idle = 1'b1;
    repeat (2) @(negedge clk);
    chk(fifo, MLRC_FIFO_WMASK);
    {k1, div} = 9'h102;
    repeat (9) pulse;
    k1 = 1'b0;
    repeat (4) pulse;
    repeat (2) @(negedge clk);
    chk(8'(nt), 8'h07);
    chk(8'(q.size()), 8'h00);
    end_sim;
  end
endmodule
`default_nettype wire
